// ==== pc_stack_defs.svh ====
// constants for program counter sequencing, return stack and indirect addressing
`ifndef PC_STACK_DEFS_SVH
`define PC_STACK_DEFS_SVH

`define PC_WIDTH        13
`define PC_RESET        13'h0000
`define HIGH_LATCH_BITS 5
`define HIGH_LATCH_RST  8'h00
`define FILE_PTR_RST    8'h00
`define JUMP_OP_BITS    11
`define JUMP_PAGE_HI    4
`define JUMP_PAGE_LO    3
`define STACK_DEPTH     8
`define STACK_PTR_BITS  3
`define DATA_ADDR_BITS  9
`define INDIRECT_ADDR   7'h00
`define INDIRECT_EMPTY  8'h00

`endif

// ==== pc_stack_pkg.sv ====
// types for program counter sequencing
`default_nettype none
package pc_stack_pkg;
	// how the counter advances in one instruction
	typedef enum logic [2:0] {
		PC_STEP,
		PC_LOW_WRITE,
		PC_JUMP,
		PC_CALL,
		PC_RETURN,
		PC_INTERRUPT
	} pc_action_e;

	typedef logic [12:0] pc_t;
endpackage : pc_stack_pkg
`default_nettype wire

// ==== return_stack.sv ====
// circular return stack of counter values
`timescale 1ns/1ps
`default_nettype none
`include "pc_stack_defs.svh"
module return_stack #(
	parameter int DEPTH    = `STACK_DEPTH,
	parameter int PTR_BITS = `STACK_PTR_BITS,
	parameter int WIDTH    = `PC_WIDTH
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] push_value,
	output logic      [WIDTH-1:0] top_value
);
	logic [WIDTH-1:0]    entry [DEPTH];
	logic [WIDTH-1:0]    next_entry [DEPTH];
	logic [PTR_BITS-1:0] ptr;
	logic [PTR_BITS-1:0] next_ptr;

	// top is the last pushed slot; no overflow or underflow flag exists [RL11]
	assign top_value = entry[PTR_BITS'(ptr - 1'b1)];

	// pointer wraps modulo depth, so a ninth push overwrites the first [RL10] [RL17]
	always_comb begin
		next_ptr = ptr;
		for (int i = 0; i < DEPTH; i++) begin
			next_entry[i] = entry[i];
		end
		if (push) begin
			next_entry[ptr] = push_value;
			next_ptr = PTR_BITS'(ptr + 1'b1);
		end else if (pop) begin
			next_ptr = PTR_BITS'(ptr - 1'b1);
		end
	end

	// pointer is internal only, never reachable by software [RL6]
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ptr <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				entry[i] <= '0;
			end
		end else begin
			ptr <= next_ptr;
			entry <= next_entry;
		end
	end

	// ******************************************************
	// assertions
	// ******************************************************
	property p_push_pop_restores;
		@(posedge mclk) disable iff (!rst_n)
		(push && !pop) ##1 (pop && !push) |-> (top_value == $past(push_value));
	endproperty
	a_push_pop_restores: assert property (p_push_pop_restores) // [RL8]
		else $error("pop after push did not return pushed value");

	property p_wrap_overwrite;
		@(posedge mclk) disable iff (!rst_n)
		push && !pop |=> (entry[$past(ptr)] == $past(push_value));
	endproperty
	a_wrap_overwrite: assert property (p_wrap_overwrite) // [RL10]
		else $error("push did not store into pointer slot");

	property p_pop_moves_back;
		@(posedge mclk) disable iff (!rst_n)
		pop && !push |=> ptr == PTR_BITS'($past(ptr) - 1'b1);
	endproperty
	a_pop_moves_back: assert property (p_pop_moves_back) // [RL17]
		else $error("pop did not move pointer back by one");

	c_wrap: cover property (@(posedge mclk) disable iff (!rst_n) push && ptr == PTR_BITS'(DEPTH - 1));
endmodule : return_stack
`default_nettype wire

// ==== pc_stack_indirect_addressing.sv ====
// program counter, return stack and indirect data address
// Behaviour
// (RL1) 13-bit counter; low byte writable, high from latch
// (RL2) any reset clears counter to zero
// (RL3) low-byte write loads high bits from latch
// (RL4) call/goto: operand low eleven, latch bits 4:3
// (RL5) low-byte arithmetic wraps without carry upward
// (RL6) eight-deep stack, pointer hidden from software
// (RL7) push on call or interrupt vector
// (RL8) pop on return, literal return, interrupt return
// (RL9) push/pop never touch high latch
// (RL10) stack is circular, ninth push overwrites first
// (RL11) no overflow or underflow status
// (RL12) indirect port accesses location at pointer
// (RL13) indirect read of itself returns zero
// (RL14) indirect write of itself stores nothing
// (RL15) address is bank bit then 8-bit pointer
// (RL16) otherwise counter increments, wrapping at top
// (RL17) extra pops wrap pointer silently, no error
`timescale 1ns/1ps
`default_nettype none
`include "pc_stack_defs.svh"
module pc_stack_indirect_addressing #(
	parameter logic [12:0] INT_VECTOR = 13'h0004
) (
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	input  wire logic                   fetch,
	input  wire pc_stack_pkg::pc_action_e action,
	input  wire logic [10:0]            jump_operand,
	input  wire logic [7:0]             alu_result,
	input  wire logic                   high_latch_write,
	input  wire logic [7:0]             high_latch_data,
	input  wire logic                   file_pointer_write,
	input  wire logic [7:0]             file_pointer_data,
	input  wire logic                   indirect_bank_select,
	input  wire logic [6:0]             direct_addr,
	input  wire logic                   data_read,
	input  wire logic                   data_write,
	input  wire logic [7:0]             data_wdata,
	input  wire logic [7:0]             mem_rdata,
	output var pc_stack_pkg::pc_t       program_counter,
	output logic [7:0]                  counter_low_byte,
	output logic [7:0]                  counter_high_latch,
	output logic [7:0]                  file_pointer,
	output logic [8:0]                  mem_addr,
	output logic                        mem_write,
	output logic [7:0]                  mem_wdata,
	output logic [7:0]                  data_rdata
);
	// ******************************************************
	// program counter
	// ******************************************************
	pc_stack_pkg::pc_t next_pc;
	logic [7:0]        next_latch;
	logic [7:0]        next_fptr;
	logic [12:0]       stack_top;
	logic              push;
	logic              pop;
	logic              indirect;

	// only one action per fetch; the decoder owns priority
	assign push = fetch && (action == pc_stack_pkg::PC_CALL
		|| action == pc_stack_pkg::PC_INTERRUPT); // [RL7]
	assign pop  = fetch && action == pc_stack_pkg::PC_RETURN; // [RL8]

	// next counter from the current action
	always_comb begin
		next_pc = program_counter;
		if (fetch) begin
			case (action)
				pc_stack_pkg::PC_LOW_WRITE: begin
					// carry never reaches upper bits; software bumps the latch [RL3] [RL5]
					next_pc = {counter_high_latch[`HIGH_LATCH_BITS-1:0], alu_result};
				end
				pc_stack_pkg::PC_JUMP, pc_stack_pkg::PC_CALL: begin
					next_pc = {counter_high_latch[`JUMP_PAGE_HI:`JUMP_PAGE_LO],
						jump_operand}; // [RL4]
				end
				pc_stack_pkg::PC_RETURN: begin
					next_pc = stack_top; // [RL8]
				end
				pc_stack_pkg::PC_INTERRUPT: begin
					next_pc = INT_VECTOR;
				end
				pc_stack_pkg::PC_STEP: begin
					next_pc = 13'(program_counter + 1'b1); // [RL16]
				end
				default: begin
					next_pc = 13'(program_counter + 1'b1);
				end
			endcase
		end
	end

	// latch changes only by its own write, never by stack traffic [RL9]
	always_comb begin
		next_latch = high_latch_write ? high_latch_data : counter_high_latch;
		next_fptr  = file_pointer_write ? file_pointer_data : file_pointer;
	end

	// every reset clears the counter [RL2]
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			program_counter    <= `PC_RESET;
			counter_high_latch <= `HIGH_LATCH_RST;
			file_pointer       <= `FILE_PTR_RST;
		end else begin
			program_counter    <= next_pc;
			counter_high_latch <= next_latch;
			file_pointer       <= next_fptr;
		end
	end

	// low byte is read straight from the counter [RL1]
	assign counter_low_byte = program_counter[7:0];

	// ******************************************************
	// return stack
	// ******************************************************
	// pushed value is the address after a call, i.e. the return point; an interrupt pushes the current counter
	return_stack #(
		.DEPTH    (`STACK_DEPTH),
		.PTR_BITS (`STACK_PTR_BITS),
		.WIDTH    (`PC_WIDTH)
	) u_stack (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.push       (push),
		.pop        (pop),
		.push_value (action == pc_stack_pkg::PC_INTERRUPT ? program_counter
			: 13'(program_counter + 1'b1)),
		.top_value  (stack_top)
	);

	// ******************************************************
	// indirect addressing
	// ******************************************************
	// port has no storage; it redirects to bank bit plus pointer [RL12] [RL15]
	assign indirect = direct_addr == `INDIRECT_ADDR;

	// pointer aimed at the port itself: read zero, write dropped [RL13] [RL14]
	logic       self_ref;
	logic       read_self;
	logic       next_read_self;
	logic [8:0] next_mem_addr;
	logic       next_mem_write;
	logic [7:0] next_mem_wdata;
	logic [7:0] next_rdata;
	assign self_ref = indirect && file_pointer[6:0] == `INDIRECT_ADDR;

	// address, strobe and data leave together so a write lands where it was aimed;
	// the price is read data two cycles after the request
	always_comb begin
		next_mem_addr  = indirect ? {indirect_bank_select, file_pointer}
			: {2'b00, direct_addr}; // [RL15]
		next_mem_write = data_write && !self_ref; // [RL14]
		next_mem_wdata = data_wdata;
		next_read_self = data_read && self_ref;
		next_rdata     = read_self ? `INDIRECT_EMPTY : mem_rdata; // [RL13]
	end

	// memory request registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mem_addr   <= 9'h000;
			mem_write  <= 1'b0;
			mem_wdata  <= 8'h00;
			read_self  <= 1'b0;
			data_rdata <= `INDIRECT_EMPTY;
		end else begin
			mem_addr   <= next_mem_addr;
			mem_write  <= next_mem_write;
			mem_wdata  <= next_mem_wdata;
			read_self  <= next_read_self;
			data_rdata <= next_rdata;
		end
	end

	// ******************************************************
	// assertions
	// ******************************************************
	property p_reset_zero;
		@(posedge mclk) $rose(rst_n) |-> program_counter == `PC_RESET;
	endproperty
	a_reset_zero: assert property (p_reset_zero) // [RL2]
		else $error("counter not zero after reset");

	property p_low_write;
		@(posedge mclk) disable iff (!rst_n)
		fetch && action == pc_stack_pkg::PC_LOW_WRITE |=>
		program_counter == {$past(counter_high_latch[4:0]), $past(alu_result)};
	endproperty
	a_low_write: assert property (p_low_write) // [RL3]
		else $error("low byte write loaded wrong counter");

	property p_jump;
		@(posedge mclk) disable iff (!rst_n)
		fetch && action == pc_stack_pkg::PC_JUMP |=>
		program_counter == {$past(counter_high_latch[4:3]), $past(jump_operand)};
	endproperty
	a_jump: assert property (p_jump) // [RL4]
		else $error("jump loaded wrong counter");

	property p_step;
		@(posedge mclk) disable iff (!rst_n)
		fetch && action == pc_stack_pkg::PC_STEP |=>
		program_counter == 13'($past(program_counter) + 1'b1);
	endproperty
	a_step: assert property (p_step) // [RL16]
		else $error("counter did not step by one");

	property p_call_return;
		@(posedge mclk) disable iff (!rst_n)
		(fetch && action == pc_stack_pkg::PC_CALL)
		##1 (fetch && action == pc_stack_pkg::PC_RETURN) |=>
		program_counter == 13'($past(program_counter, 2) + 1'b1);
	endproperty
	a_call_return: assert property (p_call_return) // [RL7]
		else $error("return did not resume after call");

	property p_latch_kept;
		@(posedge mclk) disable iff (!rst_n)
		(push || pop) && !high_latch_write |=> $stable(counter_high_latch);
	endproperty
	a_latch_kept: assert property (p_latch_kept) // [RL9]
		else $error("stack traffic changed high latch");

	property p_self_read;
		@(posedge mclk) disable iff (!rst_n)
		data_read && self_ref |-> ##2 data_rdata == `INDIRECT_EMPTY;
	endproperty
	a_self_read: assert property (p_self_read) // [RL13]
		else $error("self indirect read not zero");

	property p_self_write;
		@(posedge mclk) disable iff (!rst_n)
		data_write && self_ref |=> !mem_write;
	endproperty
	a_self_write: assert property (p_self_write) // [RL14]
		else $error("self indirect write reached memory");

	property p_ind_addr;
		@(posedge mclk) disable iff (!rst_n)
		indirect |=> mem_addr == $past({indirect_bank_select, file_pointer});
	endproperty
	a_ind_addr: assert property (p_ind_addr) // [RL15]
		else $error("indirect address wrong");

	c_call: cover property (@(posedge mclk) disable iff (!rst_n) push);
	c_ret: cover property (@(posedge mclk) disable iff (!rst_n) pop);
	c_ind: cover property (@(posedge mclk) disable iff (!rst_n) indirect && data_write);
endmodule : pc_stack_indirect_addressing
`default_nettype wire

// ==== data_memory_model.sv ====
// behavioural data memory on the far side of the indirect address port
`timescale 1ns/1ps
`default_nettype none
module data_memory_model (
	input  wire logic       mclk,
	input  wire logic [8:0] mem_addr,
	input  wire logic       mem_write,
	input  wire logic [7:0] mem_wdata,
	output logic      [7:0] mem_rdata
);
	logic [7:0] cells [512];

	// ************************************************************
	// storage: read is combinational, write on the strobe edge
	// ************************************************************
	assign mem_rdata = cells[mem_addr];

	always @(posedge mclk) begin
		if (mem_write) begin
			cells[mem_addr] <= mem_wdata; // full 9-bit address
		end
	end
endmodule : data_memory_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for counter sequencing, return stack and indirect port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [12:0] INT_VEC = 13'h0004;
	logic                     mclk = 1'b0;
	logic                     rst_n = 1'b0;
	logic                     fetch = 1'b0;
	pc_stack_pkg::pc_action_e action = pc_stack_pkg::PC_STEP;
	logic [10:0]              jump_operand = 11'h000;
	logic [7:0]               alu_result = 8'h00;
	logic                     high_latch_write = 1'b0;
	logic [7:0]               high_latch_data = 8'h00;
	logic                     file_pointer_write = 1'b0;
	logic [7:0]               file_pointer_data = 8'h00;
	logic                     indirect_bank_select = 1'b0;
	logic [6:0]               direct_addr = 7'h00;
	logic                     data_read = 1'b0;
	logic                     data_write = 1'b0;
	logic [7:0]               data_wdata = 8'h00;
	logic [7:0]               mem_rdata;
	pc_stack_pkg::pc_t        program_counter;
	logic [7:0]               counter_low_byte;
	logic [7:0]               counter_high_latch;
	logic [7:0]               file_pointer;
	logic [8:0]               mem_addr;
	logic                     mem_write;
	logic [7:0]               mem_wdata;
	logic [7:0]               data_rdata;
	int                       fail_count = 0;
	int                       comparisons = 0;
	int                       seed;
	logic [31:0]              rnd;
	logic [12:0]              m_pc = 13'h0000;
	logic [7:0]               m_lat = 8'h00;
	logic [12:0]              stk [8] = '{default: 13'h0000};
	logic [2:0]               sp = 3'h0;

	always #25 mclk = ~mclk;

	pc_stack_indirect_addressing #(.INT_VECTOR(INT_VEC)) pc_stack_indirect_addressing_inst (
		.mclk(mclk), .rst_n(rst_n), .fetch(fetch), .action(action),
		.jump_operand(jump_operand), .alu_result(alu_result),
		.high_latch_write(high_latch_write), .high_latch_data(high_latch_data),
		.file_pointer_write(file_pointer_write), .file_pointer_data(file_pointer_data),
		.indirect_bank_select(indirect_bank_select), .direct_addr(direct_addr),
		.data_read(data_read), .data_write(data_write), .data_wdata(data_wdata),
		.mem_rdata(mem_rdata), .program_counter(program_counter),
		.counter_low_byte(counter_low_byte), .counter_high_latch(counter_high_latch),
		.file_pointer(file_pointer), .mem_addr(mem_addr), .mem_write(mem_write),
		.mem_wdata(mem_wdata), .data_rdata(data_rdata));

	data_memory_model data_memory_model_inst (.mclk(mclk), .mem_addr(mem_addr),
		.mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	// ************************************************************
	// comparison, verdict and expectation helpers
	// ************************************************************
	task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic test_done;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	// self reference is decided on pointer bits 6:0 only, in both banks
	function automatic logic ind_self(input logic [6:0] dir, input logic [7:0] ptr);
		return dir == 7'h00 && ptr[6:0] == 7'h00;
	endfunction : ind_self

	function automatic logic [7:0] ind_read(input logic [6:0] dir, input logic [7:0] ptr,
			input logic [7:0] val);
		return ind_self(dir, ptr) ? 8'h00 : val;
	endfunction : ind_read

	// the port address redirects to bank bit and pointer, any other address is direct
	function automatic logic [8:0] data_addr(input logic bank, input logic [6:0] dir,
			input logic [7:0] ptr);
		return (dir == 7'h00) ? {bank, ptr} : {2'b00, dir};
	endfunction : data_addr

	// one instruction; latch writes kept off cycles that read the latch
	task automatic cycle(input pc_stack_pkg::pc_action_e act, input logic f,
			input logic lw, input logic [7:0] ld, input logic [7:0] alu);
		fetch = f;
		action = act;
		jump_operand = 11'($random(seed));
		alu_result = alu;
		high_latch_write = lw && !(act inside {pc_stack_pkg::PC_LOW_WRITE,
			pc_stack_pkg::PC_JUMP, pc_stack_pkg::PC_CALL});
		high_latch_data = ld;
		if (f) begin
			case (act)
				pc_stack_pkg::PC_LOW_WRITE: m_pc = {m_lat[4:0], alu};
				pc_stack_pkg::PC_JUMP: m_pc = {m_lat[4:3], jump_operand};
				pc_stack_pkg::PC_CALL: begin
					stk[sp] = m_pc + 13'h0001;
					sp++;
					m_pc = {m_lat[4:3], jump_operand};
				end
				pc_stack_pkg::PC_INTERRUPT: begin
					stk[sp] = m_pc;
					sp++;
					m_pc = INT_VEC;
				end
				pc_stack_pkg::PC_RETURN: begin
					sp--;
					m_pc = stk[sp];
				end
				default: m_pc = m_pc + 13'h0001;
			endcase
		end
		if (high_latch_write) m_lat = ld;
		@(posedge mclk);
		#5;
		check("program_counter", program_counter, m_pc);
		check("counter_low_byte", counter_low_byte, m_pc[7:0]);
		check("counter_high_latch", counter_high_latch, m_lat);
	endtask : cycle

	// write through the port or a direct address, let it land, then read it back
	task automatic indirect(input logic bank, input logic [7:0] ptr, input logic [6:0] dir,
			input logic [7:0] val);
		fetch = 1'b0;
		direct_addr = dir;
		file_pointer_write = 1'b1;
		file_pointer_data = ptr;
		@(posedge mclk);
		#5;
		file_pointer_write = 1'b0;
		indirect_bank_select = bank;
		data_write = 1'b1;
		data_wdata = val;
		check("file_pointer", file_pointer, ptr);
		@(posedge mclk);
		#5;
		data_write = 1'b0;
		check("mem_addr", mem_addr, data_addr(bank, dir, ptr));
		check("mem_write", mem_write, !ind_self(dir, ptr));
		if (!ind_self(dir, ptr)) check("mem_wdata", mem_wdata, val);
		@(posedge mclk);
		#5;
		data_read = 1'b1;
		@(posedge mclk);
		#5;
		data_read = 1'b0;
		@(posedge mclk);
		#5;
		check("data_rdata", data_rdata, ind_read(dir, ptr, val));
	endtask : indirect

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		seed = 32'h40ed;
		repeat (12) @(posedge mclk);
		#5 rst_n = 1'b1;
		check("program_counter", program_counter, 13'h0000);
		// nesting deeper than the stack so the oldest entries are overwritten
		for (int i = 0; i < 10; i++) cycle(pc_stack_pkg::PC_CALL, 1'b1, 1'b0, 8'h00, 8'h00);
		for (int i = 0; i < 10; i++) cycle(pc_stack_pkg::PC_RETURN, 1'b1, 1'b0, 8'h00, 8'h00);
		// top address then step: full counter wraps to zero
		cycle(pc_stack_pkg::PC_STEP, 1'b1, 1'b1, 8'hff, 8'h00);
		cycle(pc_stack_pkg::PC_LOW_WRITE, 1'b1, 1'b0, 8'h00, 8'hff);
		cycle(pc_stack_pkg::PC_STEP, 1'b1, 1'b0, 8'h00, 8'h00);
		cycle(pc_stack_pkg::PC_INTERRUPT, 1'b1, 1'b0, 8'h00, 8'h00);
		for (int i = 0; i < 400; i++) begin
			rnd = $random(seed);
			cycle(pc_stack_pkg::pc_action_e'(3'(rnd[2:0] % 3'd6)), rnd[3], rnd[4],
				rnd[15:8], rnd[23:16]);
		end
		for (int i = 0; i < 24; i++) begin
			rnd = $random(seed);
			indirect(rnd[0], (i % 4 == 0) ? {rnd[1], 7'h00} : rnd[15:8],
				(i % 3 == 1) ? rnd[30:24] : 7'h00, rnd[23:16]);
		end
		// second reset at the end of the run clears counter, file pointer and latch
		rst_n = 1'b0;
		#60 check("program_counter", program_counter, 13'h0000);
		check("file_pointer", file_pointer, 8'h00);
		check("counter_high_latch", counter_high_latch, 8'h00);
		test_done();
	end

	// watchdog: the sequence needs well under 3000 cycles
	initial begin
		#(50 * 20000);
		fail_count++;
		test_done();
	end
endmodule : tb_top
`default_nettype wire
